// file: common/pfhc_cfg.svh
// Timing counts, widths and command codes for the parallel flash host controller
`ifndef PFHC_CFG_SVH
`define PFHC_CFG_SVH
// Clock period in ns (20 MHz)
`define PFHC_CLK_NS        50
// Strobe phase lengths in ns; a least time, rounded up to whole cycles
`define PFHC_SETUP_NS      100
`define PFHC_SETUP_CYC     (((`PFHC_SETUP_NS) + (`PFHC_CLK_NS) - 1) / (`PFHC_CLK_NS))
`define PFHC_PULSE_NS      100
`define PFHC_PULSE_CYC     (((`PFHC_PULSE_NS) + (`PFHC_CLK_NS) - 1) / (`PFHC_CLK_NS))
// Longest internal program time in us, and the cycles it spans
`define PFHC_PROG_US       20
`define PFHC_PROG_CYC      (((`PFHC_PROG_US) * 1000) / (`PFHC_CLK_NS))
// Polling timeout: twice the longest program time
`define PFHC_POLL_MAX      (2 * (`PFHC_PROG_CYC))
// Write unlock sequence addresses and data
`define PFHC_UNL_A0        19'h05555
`define PFHC_UNL_D0        8'hAA
`define PFHC_UNL_A1        19'h02AAA
`define PFHC_UNL_D1        8'h55
`define PFHC_UNL_A2        19'h05555
`define PFHC_UNL_D2        8'hA0
// Status bit positions
`define PFHC_POLL_BIT      7
`define PFHC_TOGGLE_BIT    6
// Widest array address (largest density)
`define PFHC_ADDR_W        19
`endif

// file: common/pfhc_pkg.sv
// Types shared by the parallel flash host controller
package pfhc_pkg;
  // Controller states, Gray coded along the main path
  typedef enum logic [3:0] {
    PFHC_IDLE  = 4'h0,
    PFHC_SETUP = 4'h1,
    PFHC_PULSE = 4'h3,
    PFHC_HOLD  = 4'h2,
    PFHC_RD1   = 4'h6,
    PFHC_RD2   = 4'h7,
    PFHC_DONE  = 4'h5
  } pfhc_state_e;
  // Requested operation
  typedef enum logic [1:0] {
    PFHC_OP_READ = 2'h0,
    PFHC_OP_PROG = 2'h1
  } pfhc_op_e;
endpackage : pfhc_pkg

// file: logic/pfhc_sync.sv
// Two-flop synchroniser for the returned data bus
`timescale 1ns/100ps
`include "pfhc_cfg.svh"
module pfhc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;  // First stage, read only by second stage
  // ****************************************
  // Synchroniser stages
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_ff <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule : pfhc_sync

// file: logic/pfhc_ctrl.sv
// Host-side controller driving a byte-wide parallel NOR flash
// Operation
// - Write needs strobe and select both low
// - Read with select and gate both low
// - Caller erases sector before programming byte; controller issues no erase
// - Host writes three unlock bytes first
// - Fourth write carries target address and data
`timescale 1ns/100ps
`include "pfhc_cfg.svh"
module pfhc_ctrl #(
  parameter int ADDR_W   = 17,                 // 17/18/19 for the three densities
  parameter int POLL_MAX = `PFHC_POLL_MAX      // Polling timeout, cycles
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              req,
  input  wire logic              req_prog,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [7:0]        req_data,
  output logic                   busy,
  output logic                   done,
  output logic                   fail,
  output logic [7:0]             rd_data,
  output logic                   flash_ce_b,
  output logic                   flash_oe_b,
  output logic                   flash_we_b,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [7:0]             byte_data_lines_o,
  output logic                   byte_data_lines_oe,
  input  wire logic [7:0]        byte_data_lines_i
);
  localparam int SW = 3;                                 // Phase counter width
  localparam int PW = $clog2(POLL_MAX + 1);              // Poll counter width
  localparam logic [SW-1:0] SETUP_N = SW'(`PFHC_SETUP_CYC);
  localparam logic [SW-1:0] PULSE_N = SW'(`PFHC_PULSE_CYC);
  localparam logic [PW-1:0] POLL_N  = PW'(POLL_MAX);

  pfhc_pkg::pfhc_state_e state_ff, nxt_state;   // Sequencer state
  pfhc_pkg::pfhc_op_e    op_ff;                 // Operation in progress
  logic [SW-1:0]         ph_ff;                 // Phase cycle count
  logic [1:0]            wr_ff;                 // Write cycle index 0..3
  logic [PW-1:0]         poll_ff;               // Polling cycles used
  logic [7:0]            tgt_ff;                // Byte being programmed
  logic [ADDR_W-1:0]     tgt_a_ff;              // Target address
  logic [7:0]            prev_ff;               // Previous status read
  logic                  ok_ff;                 // Completion seen at last status read
  logic [7:0]            din_s;                 // Synchronised data bus

  // ****************************************
  // Data bus synchroniser
  // ****************************************
  pfhc_sync #(.W(8)) u_sync (
    .clk  (clk),
    .rst_b(rst_b),
    .din  (byte_data_lines_i),
    .dout (din_s)
  );

  // ****************************************
  // Decode
  // ****************************************
  wire logic ph_end   = (ph_ff == PULSE_N);                     // Phase length reached
  wire logic set_end  = (ph_ff == SETUP_N);                     // Setup length reached
  wire logic last_wr  = (wr_ff == 2'h3);                        // Fourth write done
  wire logic is_prog  = (op_ff == pfhc_pkg::PFHC_OP_PROG);
  // Bit 6 stops toggling and bit 7 matches the target data bit 7 once programmed
  wire logic stable   = (din_s[`PFHC_TOGGLE_BIT] == prev_ff[`PFHC_TOGGLE_BIT]) &&
                        (din_s[`PFHC_POLL_BIT] == tgt_ff[`PFHC_POLL_BIT]);
  wire logic timeout  = (poll_ff == POLL_N);
  // Unlock sequence words, then target for the fourth write
  wire logic [ADDR_W-1:0] wr_addr =
      (wr_ff == 2'h0) ? ADDR_W'(`PFHC_UNL_A0) :
      (wr_ff == 2'h1) ? ADDR_W'(`PFHC_UNL_A1) :
      (wr_ff == 2'h2) ? ADDR_W'(`PFHC_UNL_A2) : tgt_a_ff;
  wire logic [7:0] wr_data =
      (wr_ff == 2'h0) ? `PFHC_UNL_D0 :
      (wr_ff == 2'h1) ? `PFHC_UNL_D1 :
      (wr_ff == 2'h2) ? `PFHC_UNL_D2 : tgt_ff;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pfhc_pkg::PFHC_IDLE:  if (req) nxt_state = pfhc_pkg::PFHC_SETUP;
      pfhc_pkg::PFHC_SETUP: if (set_end) nxt_state = pfhc_pkg::PFHC_PULSE;
      pfhc_pkg::PFHC_PULSE: if (ph_end) nxt_state = is_prog ? pfhc_pkg::PFHC_HOLD : pfhc_pkg::PFHC_DONE;
      pfhc_pkg::PFHC_HOLD: begin
        // After the fourth write, only status reads follow
        if (set_end) nxt_state = last_wr ? pfhc_pkg::PFHC_RD1 : pfhc_pkg::PFHC_SETUP;
      end
      pfhc_pkg::PFHC_RD1:   if (ph_end) nxt_state = pfhc_pkg::PFHC_RD2;
      pfhc_pkg::PFHC_RD2: begin
        // Decide on the status taken while the read pulse still stood
        if (set_end && (ok_ff || timeout)) nxt_state = pfhc_pkg::PFHC_DONE;
        else if (set_end) nxt_state = pfhc_pkg::PFHC_RD1;
      end
      pfhc_pkg::PFHC_DONE:  nxt_state = pfhc_pkg::PFHC_IDLE;
      default:              nxt_state = pfhc_pkg::PFHC_IDLE;
    endcase
  end

  // ****************************************
  // State and counters
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= pfhc_pkg::PFHC_IDLE;
      ph_ff    <= '0;
    end else begin
      state_ff <= nxt_state;
      ph_ff    <= (nxt_state != state_ff) ? '0 : ph_ff + SW'(1);
    end
  end

  // Request capture and write index
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      op_ff    <= pfhc_pkg::PFHC_OP_READ;
      tgt_ff   <= 8'h00;
      tgt_a_ff <= '0;
      wr_ff    <= 2'h0;
    end else if (state_ff == pfhc_pkg::PFHC_IDLE && req) begin
      // Caller keeps the target sector erased before a program
      op_ff    <= req_prog ? pfhc_pkg::PFHC_OP_PROG : pfhc_pkg::PFHC_OP_READ;
      tgt_ff   <= req_data;
      tgt_a_ff <= req_addr;
      wr_ff    <= 2'h0;
    end else if (state_ff == pfhc_pkg::PFHC_HOLD && set_end && !last_wr) begin
      wr_ff <= wr_ff + 2'h1;
    end
  end

  // Status history and poll budget
  // Status is taken at the end of the read pulse, before the bus is released
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_ff <= 8'h00;
      ok_ff   <= 1'b0;
      poll_ff <= '0;
    end else if (state_ff == pfhc_pkg::PFHC_IDLE) begin
      ok_ff   <= 1'b0;
      poll_ff <= '0;
    end else if (state_ff == pfhc_pkg::PFHC_RD1 && ph_end) begin
      prev_ff <= din_s;
      ok_ff   <= stable;
      if (!timeout) poll_ff <= poll_ff + PW'(1);
    end else if (state_ff == pfhc_pkg::PFHC_RD1 || state_ff == pfhc_pkg::PFHC_RD2) begin
      if (!timeout) poll_ff <= poll_ff + PW'(1);
    end
  end

  // ****************************************
  // Pin drive: all outputs registered
  // ****************************************
  wire logic wr_ph   = is_prog && (state_ff == pfhc_pkg::PFHC_SETUP || state_ff == pfhc_pkg::PFHC_PULSE);
  wire logic rd_ph   = (!is_prog && (state_ff == pfhc_pkg::PFHC_SETUP || state_ff == pfhc_pkg::PFHC_PULSE)) ||
                       state_ff == pfhc_pkg::PFHC_RD1;
  wire logic nxt_wr  = is_prog && nxt_state == pfhc_pkg::PFHC_PULSE;
  wire logic nxt_rd  = (!is_prog && nxt_state == pfhc_pkg::PFHC_PULSE) || nxt_state == pfhc_pkg::PFHC_RD1;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_ce_b         <= 1'b1;
      flash_oe_b         <= 1'b1;
      flash_we_b         <= 1'b1;
      flash_addr         <= '0;
      byte_data_lines_o  <= 8'h00;
      byte_data_lines_oe <= 1'b0;
    end else begin
      // Select low during any access, high otherwise for standby
      flash_ce_b         <= !(nxt_wr || nxt_rd || wr_ph);
      flash_oe_b         <= !nxt_rd;
      flash_we_b         <= !nxt_wr;
      flash_addr         <= is_prog && !rd_ph ? wr_addr : tgt_a_ff;
      byte_data_lines_o  <= wr_data;
      byte_data_lines_oe <= wr_ph || nxt_wr;
    end
  end

  // Result outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      fail    <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      busy <= (nxt_state != pfhc_pkg::PFHC_IDLE);
      done <= (nxt_state == pfhc_pkg::PFHC_DONE);
      if (state_ff == pfhc_pkg::PFHC_PULSE && !is_prog && ph_end) rd_data <= din_s;
      if (state_ff == pfhc_pkg::PFHC_RD2 && nxt_state == pfhc_pkg::PFHC_DONE) fail <= !ok_ff;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_no_contention: assert property (@(posedge clk) disable iff (!rst_b)
    !(!flash_oe_b && byte_data_lines_oe)) else $error("data driven during read");
  a_we_needs_ce: assert property (@(posedge clk) disable iff (!rst_b)
    !flash_we_b |-> !flash_ce_b) else $error("write strobe without select");
  a_data_stable_we: assert property (@(posedge clk) disable iff (!rst_b)
    !flash_we_b |=> byte_data_lines_oe) else $error("data dropped before strobe rise");
  a_four_writes: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == pfhc_pkg::PFHC_RD1 && $past(state_ff) == pfhc_pkg::PFHC_HOLD) |-> wr_ff == 2'h3)
    else $error("poll before four writes");
  a_poll_bound: assert property (@(posedge clk) disable iff (!rst_b)
    poll_ff <= POLL_N) else $error("poll counter overrun");
  a_done_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    done |=> !done) else $error("done longer than one cycle");
  a_idle_pins: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == pfhc_pkg::PFHC_IDLE && $past(state_ff) == pfhc_pkg::PFHC_IDLE) |-> flash_ce_b && flash_we_b)
    else $error("pins active while idle");
  a_ignore_req: assert property (@(posedge clk) disable iff (!rst_b)
    (busy && req && state_ff != pfhc_pkg::PFHC_IDLE) |=> $stable(tgt_ff)) else $error("request taken while busy");
  c_prog: cover property (@(posedge clk) disable iff (!rst_b) done && is_prog && !fail);
  c_read: cover property (@(posedge clk) disable iff (!rst_b) done && !is_prog);
  c_fail: cover property (@(posedge clk) disable iff (!rst_b) fail);
endmodule : pfhc_ctrl

// file: bench/pfhc_flash_mdl.sv
// Behavioural byte-wide flash device facing the host controller
`timescale 1ns/100ps
`include "pfhc_cfg.svh"
module pfhc_flash_mdl #(
  parameter int ADDR_W = 17
) (
  input  wire logic              ce_b,
  input  wire logic              oe_b,
  input  wire logic              we_b,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        dq_in,
  input  int                     prog_ns,
  output logic [7:0]             dq_out,
  output logic                   dq_oe,
  output logic                   prog_busy
);
  logic [7:0]        mem [0:(1<<ADDR_W)-1]; // Array, starts erased
  logic [ADDR_W-1:0] lat_a;                 // Latched write address
  logic [ADDR_W-1:0] prog_a;                // Byte being programmed
  logic [7:0]        prog_d;                // Value being programmed
  logic              tog;                   // Toggling status bit
  int                unl;                   // Unlock bytes seen
  wire               wr_sel = ce_b | we_b;  // Low only in a write
  wire               rd_sel = ce_b | oe_b;  // Low only in a read
  // ********************
  // Power-up state
  // ********************
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = 8'hFF;
    end
    prog_busy = 1'b0;
    tog = 1'b0;
    unl = 0;
  end
  // Address taken at the later falling edge
  always @(negedge wr_sel) if (oe_b === 1'b1) lat_a = addr;
  // Data taken at the earlier rising edge; ignored while busy
  always @(posedge wr_sel) begin
    if (oe_b === 1'b1 && !prog_busy) begin
      case (unl)
        0: unl = (lat_a == ADDR_W'(`PFHC_UNL_A0) && dq_in == `PFHC_UNL_D0) ? 1 : 0;
        1: unl = (lat_a == ADDR_W'(`PFHC_UNL_A1) && dq_in == `PFHC_UNL_D1) ? 2 : 0;
        2: unl = (lat_a == ADDR_W'(`PFHC_UNL_A2) && dq_in == `PFHC_UNL_D2) ? 3 : 0;
        default: begin
          // Fourth write starts the program, status valid at once
          prog_a = lat_a;
          prog_d = dq_in;
          prog_busy = 1'b1;
          unl = 0;
          fork
            begin
              #(prog_ns);
              mem[prog_a] = mem[prog_a] & prog_d;
              prog_busy = 1'b0;
            end
          join_none
        end
      endcase
    end
  end
  // Each finished status read flips the toggle bit
  always @(posedge rd_sel) if (prog_busy) tog = ~tog;
  // Drive only with select and gate low, status only while busy
  assign dq_oe  = !ce_b && !oe_b;
  assign dq_out = prog_busy ? {~prog_d[7], tog, 6'h15} : mem[addr];
endmodule : pfhc_flash_mdl

// file: bench/parallel_flash_read_program_port_tb.sv
// Self-checking bench for the parallel flash host controller
`timescale 1ns/100ps
module parallel_flash_read_program_port_tb;
  localparam int AW = 17;      // Smallest density
  logic          clk, rst_b, req, req_prog, busy, done, fail;
  logic          ce_b, oe_b, we_b, d_oe, m_oe, m_busy;
  logic [AW-1:0] req_addr, f_addr, a;
  logic [7:0]    req_data, rd_data, d_o, m_o, junk, d;
  int            prog_ns, n_fail, comparisons;
  logic [7:0]    ref_mem [int]; // Reference array, absent means erased
  // Released bus shows a moving pattern
  wire  [7:0]    dq_i = (d_oe === 1'b1) ? d_o : (m_oe === 1'b1) ? m_o : junk;
  pfhc_ctrl #(.ADDR_W(AW)) dut_u (.clk(clk), .rst_b(rst_b), .req(req), .req_prog(req_prog),
    .req_addr(req_addr), .req_data(req_data), .busy(busy), .done(done), .fail(fail),
    .rd_data(rd_data), .flash_ce_b(ce_b), .flash_oe_b(oe_b), .flash_we_b(we_b),
    .flash_addr(f_addr), .byte_data_lines_o(d_o), .byte_data_lines_oe(d_oe),
    .byte_data_lines_i(dq_i));
  pfhc_flash_mdl #(.ADDR_W(AW)) mdl_u (.ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .addr(f_addr),
    .dq_in(dq_i), .prog_ns(prog_ns), .dq_out(m_o), .dq_oe(m_oe), .prog_busy(m_busy));
  // Clock and idle-bus pattern
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) junk <= junk + 8'h3B;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // One operation; stray raises a request mid-run that must be ignored
  task automatic op(input logic prog, input logic [AW-1:0] ad, input logic [7:0] dt,
                    input logic stray, input logic efail);
    int n;
    logic [7:0] e;
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(posedge clk);
      #5;
      n++;
    end
    if (n >= 50) begin
      n_fail++;
      close_out();
    end
    req = 1'b1;
    req_prog = prog;
    req_addr = ad;
    req_data = dt;
    @(posedge clk);
    #5;
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #5;
      n++;
      req = stray && (n == 10);
      req_prog = 1'b0;
    end
    req = 1'b0;
    if (n >= 3000) begin
      n_fail++;
      close_out();
    end
    e = ref_mem.exists(ad) ? ref_mem[ad] : 8'hFF;
    if (prog) begin
      ref_mem[ad] = e & dt;
      chk({7'h00, fail}, {7'h00, efail});
    end else begin
      chk(rd_data, e);
    end
    repeat (3) begin
      @(posedge clk);
      #5;
      chk({6'h00, busy, done}, 8'h00);
    end
  endtask : op
  // ********************
  // Main sequence
  // ********************
  initial begin
    req = 1'b0;
    req_prog = 1'b0;
    req_addr = '0;
    req_data = 8'h00;
    junk = 8'h5A;
    prog_ns = 1000;
    n_fail = 0;
    comparisons = 0;
    rst_b = 1'b0;
    void'($urandom(25));
    repeat (3) @(posedge clk);
    #5;
    rst_b = 1'b1;
    chk({2'h0, ce_b, oe_b, we_b, d_oe, busy, done}, 8'h38);
    for (int i = 0; i < 8; i++) begin
      a = AW'({5'(i), 12'($urandom)});
      d = 8'($urandom);
      prog_ns = $urandom_range(200, 20000);
      op(1'b1, a, d, i == 2, 1'b0);
      op(1'b0, a, 8'h00, 1'b0, 1'b0);
      op(1'b0, AW'($urandom), 8'h00, 1'b0, 1'b0);
    end
    a = AW'({5'h08, 12'($urandom)});
    prog_ns = 200000;
    op(1'b1, a, 8'h00, 1'b0, 1'b1);
    for (int n = 0; n < 5000 && m_busy; n++) begin
      @(posedge clk);
      #5;
    end
    if (m_busy !== 1'b0) begin
      n_fail++;
      close_out();
    end
    op(1'b0, a, 8'h00, 1'b0, 1'b0);
    close_out();
  end
endmodule : parallel_flash_read_program_port_tb
